//--- verilog/smc_map.svh
// constants of the operating-mode control register: frame layout,
// field positions, reset values and the frame length.
// assumes nothing; definitions only, included by bare name.
//
// Function
// - frame with lock bit set writes only the lock flag
// - warning bit armed means next reset drives fallback
// - any reset forces warning bit to one
// - reset sets output bit only if warning armed
// - output bit one pulls fallback pin low
// - aux pin high only when bit set, Normal
// - edge-rate bit picks 20 or 10.4 kbit/s
// - bias bit: pin drive or 16/64 ms sampling
// - share bit picks transistor current thresholds
// - frame: select, lock bit, twelve data bits
// - status shifted out while control shifted in
// - sample falling edge, shift rising, clock idles low
// - wake from Sleep rewrites mode field to 00
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// frame geometry
`define SMC_FRAME_BITS      16
`define SMC_CNT_W           5
`define SMC_SEL_HI          15
`define SMC_SEL_LO          13
`define SMC_REG_SELECT      3'h1
// field positions inside the frame
`define SMC_BIT_LOCK        12
`define SMC_MODE_HI         11
`define SMC_MODE_LO         10
`define SMC_BIT_WARN        9
`define SMC_BIT_FBOUT       8
`define SMC_BIT_AUX         7
`define SMC_BIT_SLOPE       6
`define SMC_BIT_BIAS        5
`define SMC_BIT_SHARE       4
`define SMC_RSVD_VALUE      4'h0
// reset values
`define SMC_RST_LOCK        1'h0
`define SMC_RST_MODE        2'h0
`define SMC_RST_WARN        1'h1
`define SMC_RST_FBOUT       1'h0
`define SMC_RST_AUX         1'h0
`define SMC_RST_SLOPE       1'h0
`define SMC_RST_BIAS        1'h0
`define SMC_RST_SHARE       1'h0
// mode field codes
`define SMC_MODE_STANDBY    2'h0
`define SMC_MODE_SLEEP      2'h1

`endif

//--- verilog/smc_pkg.sv
// types of the operating-mode control register block.
// assumes smc_map.svh supplies widths.
`include "smc_map.svh"

package smc_pkg;

    // spi frame phase, one-hot
    typedef enum logic [1:0] {
        SMC_IDLE  = 2'b01,
        SMC_SHIFT = 2'b10
    } smc_phase_e;

    // whole state of the register block
    typedef struct packed {
        smc_phase_e                  phase;
        logic                        sck_d;
        logic [`SMC_FRAME_BITS-1:0]  rx;
        logic [`SMC_FRAME_BITS-1:0]  tx;
        logic [`SMC_CNT_W-1:0]       cnt;
        logic                        lock;
        logic [1:0]                  mode;
        logic                        warn;
        logic                        fbout;
        logic                        aux;
        logic                        slope;
        logic                        bias;
        logic                        share;
        logic                        sdo;
        logic                        sdo_oe;
        logic                        aux_pin;
        logic                        fb_oe;
        logic                        bias_oe;
        logic                        normal_req;
    } smc_state_s;

endpackage

//--- verilog/smc_sync.sv
// two-flop synchroniser bank for pins from outside the clock domain.
// assumes inputs are asynchronous levels; output is the second flop.
`timescale 1ns/10ps

module smc_sync #(
    parameter int WIDTH    = 3,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // refuse a bank with no bits when elaborated
    if (WIDTH < 1) begin : g_bad_width
        $error("smc_sync needs at least one bit");
    end

    // both flop stages of the bank as one state word
    typedef struct packed {
        logic [WIDTH-1:0] meta;   // first stage, may go metastable
        logic [WIDTH-1:0] sync;   // second stage, safe to read
    } smc_sync_s;

    smc_sync_s state_reg;         // registered stages
    smc_sync_s state_next;        // next value of the stages

    // first stage takes the pins; only the second stage reads it
    always_comb begin
        state_next.meta = async_in;
        state_next.sync = state_reg.meta;
    end

    // both stages reset to the idle level of the pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.meta <= INIT;
            state_reg.sync <= INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // output straight from the second stage
    assign sync_out = state_reg.sync;

endmodule

//--- verilog/smc_mode_ctl.sv
// operating-mode control register with its serial port and pin drives.
// assumes spi pins arrive asynchronously and are oversampled by clk;
// sck must be slow enough that each level lasts several clk periods.
// mode state, wake events and system resets come from logic on clk.
`timescale 1ns/10ps
`include "smc_map.svh"

module smc_mode_ctl (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // serial port pins
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sck,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    output logic             spi_sdo_oe,
    // device context, same clock
    input  wire logic        device_in_normal,
    input  wire logic        sys_reset_pulse,
    input  wire logic        wake_to_standby,
    input  wire logic [1:0]  wake_sample_sync,
    // pin drives
    output logic             aux_output_pin,
    output logic             fallback_pin_out,
    output logic             fallback_pin_oe,
    output logic             wake_bias_pin_out,
    output logic             wake_bias_pin_oe,
    // control levels to the analog side
    output logic [1:0]       operating_mode_select,
    output logic             normal_mode_request,
    output logic             bus_edge_rate_sel,
    output logic             wake_bias_sel,
    output logic             pass_transistor_share_sel,
    output logic             write_lock_flag
);
    import smc_pkg::*;

    // the bit counter must pass the frame length before it saturates,
    // otherwise an overlong frame could alias onto a good count
    if (((1 << `SMC_CNT_W) - 1) <= `SMC_FRAME_BITS) begin : g_bad_cnt
        $error("bit counter too narrow for the frame length");
    end

    // synchronised pin levels; chip select idles high
    logic       cs_n_s;
    logic       sck_s;
    logic       sdi_s;
    logic [2:0] pins_s;

    // state register and its next value
    smc_state_s state_reg;
    smc_state_s state_next;

    // edges of the oversampled serial clock
    logic sck_rise;
    logic sck_fall;

    // current register image as the host reads it
    logic [`SMC_FRAME_BITS-1:0] image;

    // frame commit decode
    logic frame_done;
    logic frame_ours;

    // all three spi pins cross into clk here
    // two flops of lag are harmless: each sck level spans several clk
    smc_sync #(
        .WIDTH (3),
        .INIT  (3'b100)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({spi_cs_n, spi_sck, spi_sdi}),
        .sync_out (pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sck_s  = pins_s[1];
    assign sdi_s  = pins_s[0];

    // edge detect on the synchronised clock only
    // sck_d resets low to match the idle clock, so no false edge follows
    assign sck_rise = sck_s & ~state_reg.sck_d;
    assign sck_fall = ~sck_s & state_reg.sck_d;

    // read image: select bits fixed, reserved low nibble zero
    // the image is also the status word sent back in every frame
    always_comb begin
        image = '0;
        image[`SMC_SEL_HI:`SMC_SEL_LO]   = `SMC_REG_SELECT;
        image[`SMC_BIT_LOCK]             = state_reg.lock;
        image[`SMC_MODE_HI:`SMC_MODE_LO] = state_reg.mode;
        image[`SMC_BIT_WARN]             = state_reg.warn;
        image[`SMC_BIT_FBOUT]            = state_reg.fbout;
        image[`SMC_BIT_AUX]              = state_reg.aux;
        image[`SMC_BIT_SLOPE]            = state_reg.slope;
        image[`SMC_BIT_BIAS]             = state_reg.bias;
        image[`SMC_BIT_SHARE]            = state_reg.share;
        image[3:0]                       = `SMC_RSVD_VALUE;
    end

    // a frame counts only when exactly sixteen bits were sampled
    // a cut or overlong frame is dropped silently; the host must resend it
    assign frame_done = (state_reg.phase == SMC_SHIFT) && cs_n_s;
    assign frame_ours = (state_reg.cnt == `SMC_CNT_W'(`SMC_FRAME_BITS))
                        && (state_reg.rx[`SMC_SEL_HI:`SMC_SEL_LO] == `SMC_REG_SELECT);

    // next-state logic: serial engine, register updates, pin drives
    always_comb begin
        state_next       = state_reg;
        state_next.sck_d = sck_s;

        unique case (state_reg.phase)
            SMC_IDLE: begin
                // chip select low: capture status to send back
                if (!cs_n_s) begin
                    state_next.phase = SMC_SHIFT;
                    state_next.tx    = image;
                    state_next.cnt   = '0;
                    state_next.rx    = '0;
                end
            end
            SMC_SHIFT: begin
                if (cs_n_s) begin
                    state_next.phase = SMC_IDLE;
                end else begin
                    // rising edge presents the next status bit
                    if (sck_rise) begin
                        state_next.sdo = state_reg.tx[`SMC_FRAME_BITS-1];
                        state_next.tx  = {state_reg.tx[`SMC_FRAME_BITS-2:0], 1'b0};
                    end
                    // falling edge samples host data, msb first
                    if (sck_fall) begin
                        state_next.rx = {state_reg.rx[`SMC_FRAME_BITS-2:0], sdi_s};
                        // saturate so overlong frames stay rejected
                        if (state_reg.cnt != '1) begin
                            state_next.cnt = state_reg.cnt + `SMC_CNT_W'(1);
                        end
                    end
                end
            end
            // a stray phase code from an upset falls back to idle
            default: begin
                state_next.phase = SMC_IDLE;
            end
        endcase

        // commit a frame for this register at chip select release
        if (frame_done && frame_ours) begin
            state_next.lock = state_reg.rx[`SMC_BIT_LOCK];
            // a lock bit of one leaves every field but the lock flag untouched
            if (!state_reg.rx[`SMC_BIT_LOCK]) begin
                state_next.mode  = state_reg.rx[`SMC_MODE_HI:`SMC_MODE_LO];
                state_next.warn  = state_reg.rx[`SMC_BIT_WARN];
                state_next.fbout = state_reg.rx[`SMC_BIT_FBOUT];
                state_next.aux   = state_reg.rx[`SMC_BIT_AUX];
                state_next.slope = state_reg.rx[`SMC_BIT_SLOPE];
                state_next.bias  = state_reg.rx[`SMC_BIT_BIAS];
                state_next.share = state_reg.rx[`SMC_BIT_SHARE];
            end
        end

        // wake from sleep overrides the mode field of a write landing in the same cycle
        // limitation: the host sees this only by reading the register back
        if (wake_to_standby) begin
            state_next.mode = `SMC_MODE_STANDBY;
        end

        // system reset: arm warning, latch pending warning into output
        // the old warning is read from state_reg, so the order of these two lines does not matter
        if (sys_reset_pulse) begin
            state_next.fbout = state_reg.warn;
            state_next.warn  = `SMC_RST_WARN;
        end

        // pin drives from the fields about to be held
        // computed from next values so they move together with the fields
        state_next.sdo_oe     = (state_next.phase == SMC_SHIFT);
        state_next.aux_pin    = state_next.aux && device_in_normal;
        state_next.fb_oe      = state_next.fbout;
        // bias pin is driven only while no wake input samples by it
        state_next.bias_oe    = state_next.bias && (wake_sample_sync == 2'h0);
        state_next.normal_req = state_next.mode[1];
        if (state_next.phase == SMC_IDLE) begin
            state_next.sdo = 1'b0;
        end
    end

    // single state register
    // async reset loads constants only; unlisted fields start at zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg            <= '0;
            state_reg.phase      <= SMC_IDLE;
            state_reg.lock       <= `SMC_RST_LOCK;
            state_reg.mode       <= `SMC_RST_MODE;
            state_reg.warn       <= `SMC_RST_WARN;
            state_reg.fbout      <= `SMC_RST_FBOUT;
            state_reg.aux        <= `SMC_RST_AUX;
            state_reg.slope      <= `SMC_RST_SLOPE;
            state_reg.bias       <= `SMC_RST_BIAS;
            state_reg.share      <= `SMC_RST_SHARE;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state flops
    // fallback and bias pins only pull low: just the enable moves
    assign spi_sdo                   = state_reg.sdo;
    assign spi_sdo_oe                = state_reg.sdo_oe;
    assign aux_output_pin            = state_reg.aux_pin;
    assign fallback_pin_out          = 1'b0;                  // pin only ever pulled low
    assign fallback_pin_oe           = state_reg.fb_oe;
    assign wake_bias_pin_out         = 1'b0;
    assign wake_bias_pin_oe          = state_reg.bias_oe;
    assign operating_mode_select     = state_reg.mode;
    assign normal_mode_request       = state_reg.normal_req;
    assign bus_edge_rate_sel         = state_reg.slope;
    assign wake_bias_sel             = state_reg.bias;
    assign pass_transistor_share_sel = state_reg.share;
    assign write_lock_flag           = state_reg.lock;

endmodule

//--- verification/smc_mode_ctl_props.sv
// concurrent checks on the ports of the mode control register block.
// assumes one clock domain and is attached to smc_mode_ctl by bind.
`timescale 1ns/10ps

module smc_mode_ctl_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // serial port and device context
    input wire logic       spi_cs_n,
    input wire logic       spi_sdo,
    input wire logic       spi_sdo_oe,
    input wire logic       device_in_normal,
    input wire logic       wake_to_standby,
    input wire logic [1:0] wake_sample_sync,
    // pin drives and control levels
    input wire logic       aux_output_pin,
    input wire logic       fallback_pin_out,
    input wire logic       fallback_pin_oe,
    input wire logic       wake_bias_pin_oe,
    input wire logic [1:0] operating_mode_select,
    input wire logic       normal_mode_request,
    input wire logic       bus_edge_rate_sel,
    input wire logic       pass_transistor_share_sel,
    input wire logic       write_lock_flag
);
    // all checks share one clock and the async reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // an enabled fallback pin only ever pulls low
    property p_fb_low; fallback_pin_oe |-> !fallback_pin_out; endproperty
    a_fb_low: assert property (p_fb_low) else $error("fallback pin driven high");
    // aux pin high needs Normal one cycle earlier
    property p_aux_on; aux_output_pin |-> $past(device_in_normal); endproperty
    a_aux_on: assert property (p_aux_on) else $error("aux pin high outside Normal");
    property p_aux_off; !device_in_normal |=> !aux_output_pin; endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux pin not low");
    // both upper codes request Normal
    property p_mode_dec; normal_mode_request == operating_mode_select[1]; endproperty
    a_mode_dec: assert property (p_mode_dec) else $error("mode decode wrong");
    property p_wake; wake_to_standby |-> ##[1:2] operating_mode_select == 2'h0; endproperty
    a_wake: assert property (p_wake) else $error("wake left mode set");
    // sampling enabled means the bias pin is not pulled
    property p_bias_off; (wake_sample_sync != 2'h0) [*3] |-> !wake_bias_pin_oe; endproperty
    a_bias_off: assert property (p_bias_off) else $error("bias pin driven");
    property p_sdo_idle; !spi_sdo_oe |-> !spi_sdo; endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("data out not quiet");
    property p_oe_cs; !spi_cs_n [*5] |-> spi_sdo_oe; endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("data out not enabled");
    // edge-rate, share and lock fields only move at a frame commit, never mid-frame
    property p_hold;
        !spi_cs_n [*8] |-> $stable({bus_edge_rate_sel, pass_transistor_share_sel, write_lock_flag});
    endproperty
    a_hold: assert property (p_hold) else $error("field moved mid-frame");
    // main scenarios reached
    c_wake: cover property (wake_to_standby);
    c_lock: cover property ($rose(write_lock_flag));
    c_aux: cover property (aux_output_pin);
endmodule

bind smc_mode_ctl smc_mode_ctl_chk chk_u (
    .clk, .reset_n, .spi_cs_n, .spi_sdo, .spi_sdo_oe, .device_in_normal,
    .wake_to_standby, .wake_sample_sync, .aux_output_pin, .fallback_pin_out,
    .fallback_pin_oe, .wake_bias_pin_oe, .operating_mode_select,
    .normal_mode_request, .bus_edge_rate_sel, .pass_transistor_share_sel,
    .write_lock_flag
);

//--- verification/smc_host_model.sv
// host controller model: serial master of 16-bit full-duplex frames.
// assumes clk only spaces frames; serial clock runs at 125 ns period.
`timescale 1ns/10ps

module smc_host_model (
    // frame spacing clock
    input wire logic clk,
    // serial pins
    output logic     spi_cs_n,
    output logic     spi_sck,
    output logic     spi_sdi,
    input wire logic spi_sdo
);
    // idle: deselected, clock parked low
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
    end

    // one frame, msb first; serial clock stands still outside it
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge clk);
        // non-blocking, so the pin flops never race the select edge
        spi_cs_n <= 1'b0;
        #62.5;
        for (int i = 15; i >= 0; i--) begin
            spi_sck = 1'b1;
            spi_sdi = tx[i];
            #62.5;
            spi_sck = 1'b0;
            rx[i] = spi_sdo;
            #62.5;
        end
        spi_cs_n = 1'b1;
        // released line must not keep showing the last bit
        spi_sdi = ~spi_sdi;
        repeat (8) @(posedge clk);
    endtask
endmodule

//--- verification/testbench.sv
// self-checking bench of the mode control register block.
// assumes the host model drives the serial pins; image tracked here.
`timescale 1ns/10ps

module testbench;
    // bench driven inputs, all known at time zero
    logic        clk              = 1'b0;
    logic        reset_n          = 1'b0;
    logic        device_in_normal = 1'b0;
    logic        sys_reset_pulse  = 1'b0;
    logic        wake_to_standby  = 1'b0;
    logic [1:0]  wake_sample_sync = 2'h0;
    // serial pins and observed levels
    logic        spi_cs_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe;
    logic        aux_output_pin, fallback_pin_oe, wake_bias_pin_oe, normal_mode_request;
    logic        fallback_pin_out, wake_bias_pin_out;
    logic        bus_edge_rate_sel, wake_bias_sel, pass_transistor_share_sel, write_lock_flag;
    logic [1:0]  operating_mode_select;
    // expected image, random state, counters
    logic [15:0] img        = 16'h2200;
    logic [31:0] rnd        = 32'h8B9C803E;
    int          fail_count = 0;
    int          tests_run  = 0;
    int          cycles     = 0;

    always #5 clk = ~clk;

    smc_host_model host_u (.clk, .spi_cs_n, .spi_sck, .spi_sdi, .spi_sdo);
    smc_mode_ctl dut_u (
        .clk, .reset_n, .spi_cs_n, .spi_sck, .spi_sdi, .spi_sdo, .spi_sdo_oe,
        .device_in_normal, .sys_reset_pulse, .wake_to_standby, .wake_sample_sync,
        .aux_output_pin, .fallback_pin_out, .fallback_pin_oe, .wake_bias_pin_out,
        .wake_bias_pin_oe, .operating_mode_select, .normal_mode_request,
        .bus_edge_rate_sel, .wake_bias_sel, .pass_transistor_share_sel, .write_lock_flag
    );

    // random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // image after a committed write: select fixed, low nibble zero
    function automatic logic [15:0] img_of(input logic [15:0] w);
        return {3'h1, 1'b0, w[11:4], 4'h0};
    endfunction

    task automatic results();
        $display("mismatches %0d of %0d checks", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // word and bit comparisons
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk({15'h0, got}, {15'h0, exp}, what);
    endtask

    // one frame; the status returned is the image before commit
    task automatic frame(input logic [15:0] tx);
        logic [15:0] rx;
        host_u.xfer(tx, rx);
        chk(rx, img, "status image");
        if (tx[15:12] == 4'h3) img[12] = 1'b1;
        else if (tx[15:12] == 4'h2) img = img_of(tx);
    endtask

    // all levels against the tracked image
    task automatic fields();
        chk({14'h0, operating_mode_select}, {14'h0, img[11:10]}, "mode");
        chk1(normal_mode_request, img[11], "normal");
        chk1(bus_edge_rate_sel, img[6], "slope");
        chk1(wake_bias_sel, img[5], "bias");
        chk1(pass_transistor_share_sel, img[4], "share");
        chk1(fallback_pin_oe, img[8], "fallback");
        chk1(write_lock_flag, img[12], "lock");
        chk1(aux_output_pin, img[7] & device_in_normal, "aux");
        chk1(wake_bias_pin_oe, img[5] & (wake_sample_sync == 2'h0), "bias pin");
        chk1(spi_sdo_oe, 1'b0, "data out enable");
        chk1(fallback_pin_out, 1'b0, "fallback level");
        chk1(wake_bias_pin_out, 1'b0, "bias level");
    endtask

    // one-cycle context pulse: 1 for system reset, 0 for wake
    task automatic pulse(input logic sys);
        @(posedge clk);
        sys_reset_pulse <= sys;
        wake_to_standby <= !sys;
        @(posedge clk);
        sys_reset_pulse <= 1'b0;
        wake_to_standby <= 1'b0;
        repeat (3) @(posedge clk);
        if (sys) img = {img[15:10], 1'b1, img[9], img[7:0]};
        else img[11:10] = 2'h0;
    endtask

    // hang guard, far above the expected few thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        frame(16'h3000);
        fields();
        // every mode code, random rest including reserved bits
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            device_in_normal <= rnd[20];
            wake_sample_sync <= rnd[22:21];
            frame({4'h2, i[1:0], rnd[9:0]});
            fields();
        end
        frame({4'h3, ~img[11:0]});
        fields();
        frame({4'h4, ~img[11:0]});
        fields();
        frame({4'h2, 2'h1, img[9:0]});
        pulse(1'b0);
        fields();
        frame({4'h2, img[11:10], 1'b0, img[8:0]});
        pulse(1'b1);
        fields();
        pulse(1'b1);
        fields();
        frame(16'h3000);
        // second power-on reset in mid-run
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        img = 16'h2200;
        repeat (2) @(posedge clk);
        frame(16'h3000);
        fields();
        results();
    end
endmodule
